// ---- hw/css_pkg.sv ----
// Contract
// - clock-source fuses 0110 or 0111 select the low-frequency watch crystal.
// - crystal reset delay by startup fuses: 00 4 CK, 01 +4.1 ms, 10 +65 ms.
// - crystal wake delay is 1K CK fast or 32K CK stable.
// - clock-source fuses 0010 select the internal 8 MHz RC oscillator.
// - during reset the factory calibration byte loads into the RC trim register.
// - software may overwrite the RC trim register at run time.
// - reset time-out is timed from the watchdog oscillator regardless of source.
// - RC source waits 6 CK on wake; reset 14CK, +4.1 ms or +65 ms.
// - reset-pin-disable fuse stretches the shortest internal reset delay to 14CK + 4.1 ms.
// - shipped fuses have divide-by-eight programmed and RC startup code 10.
// - programmed divide-by-eight fuse divides the internal clock by 8.
// - clock-source fuses 0011 select the 128 kHz internal oscillator.
// - 128 kHz source waits 6 CK on wake; reset 14CK, +4 ms or +64 ms.
package css_pkg;

   // watchdog oscillator rate and documented times
   localparam int unsigned     WDT_HZ     = 128_000;
   localparam longint unsigned US_PER_S   = 64'd1_000_000;
   localparam int unsigned     T_4P1MS_US = 4100;
   localparam int unsigned     T_65MS_US  = 65000;
   localparam int unsigned     T_4MS_US   = 4000;
   localparam int unsigned     T_64MS_US  = 64000;

   // least times in watchdog ticks, rounded up
   localparam int unsigned TICKS_4P1MS = int'((64'(T_4P1MS_US) * WDT_HZ + US_PER_S - 64'd1) / US_PER_S);
   localparam int unsigned TICKS_65MS  = int'((64'(T_65MS_US) * WDT_HZ + US_PER_S - 64'd1) / US_PER_S);
   localparam int unsigned TICKS_4MS   = int'((64'(T_4MS_US) * WDT_HZ + US_PER_S - 64'd1) / US_PER_S);
   localparam int unsigned TICKS_64MS  = int'((64'(T_64MS_US) * WDT_HZ + US_PER_S - 64'd1) / US_PER_S);

   // cycle counts of the selected clock
   localparam logic [15:0] CK_LF_RESET   = 16'h0004;
   localparam logic [15:0] CK_INT_RESET  = 16'h000E;
   localparam logic [15:0] CK_INT_WAKE   = 16'h0006;
   localparam logic [15:0] CK_LF_WAKE    = 16'h0400;
   localparam int unsigned CK_LF_STABLE  = 32768;

   // clock-source and startup fuse codes
   localparam logic [3:0] SRCF_LF_FAST   = 4'h6;
   localparam logic [3:0] SRCF_LF_STABLE = 4'h7;
   localparam logic [3:0] SRCF_RC        = 4'h2;
   localparam logic [3:0] SRCF_128K      = 4'h3;
   localparam logic [1:0] SUT_SHORT      = 2'h0;
   localparam logic [1:0] SUT_MID        = 2'h1;
   localparam logic [1:0] SUT_LONG       = 2'h2;
   localparam logic [1:0] SUT_RESERVED   = 2'h3;

   // fuse word after reset: divide-by-eight on, startup 10, RC source
   localparam logic [7:0] FUSE_SHIPPED   = 8'h62;

   // one-hot source select outputs
   localparam logic [2:0] SRC_LF   = 3'h1;
   localparam logic [2:0] SRC_RC   = 3'h2;
   localparam logic [2:0] SRC_128K = 3'h4;

   // register byte offsets
   localparam logic [7:0] OFS_FUSE    = 8'h00;
   localparam logic [7:0] OFS_TRIM    = 8'h04;
   localparam logic [7:0] OFS_STATUS  = 8'h08;
   localparam logic [7:0] OFS_CONTROL = 8'h0C;
   localparam int unsigned CTRL_RESTART_BIT = 0;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // fuse word layout
   typedef struct packed {
      logic       resetPinDisableFuse;
      logic       divideByEightFuse;
      logic [1:0] startupDelayFuses;
      logic [3:0] clockSourceFuses;
   } css_fuse_t;

   // delay targets: selected-clock cycles and watchdog ticks
   typedef struct packed {
      logic [15:0] ckCount;
      logic [15:0] tickCount;
   } css_delay_t;

   typedef enum logic [2:0] {
      ST_RESET_WAIT = 3'b001,
      ST_RUN        = 3'b010,
      ST_WAKE_WAIT  = 3'b100
   } css_state_t;

endpackage : css_pkg

// ---- hw/css_pin_sync.sv ----
`timescale 1ns/10ps
module css_pin_sync
   import css_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // asynchronous pin and its clean level
   input  wire logic pinIn,
   output logic      level
);

   logic [2:0] stage;

   // three-stage shift from the pin
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stage <= 3'h0;
      end else begin
         stage <= {stage[1:0], pinIn};
      end
   end

   // change accepted once stages two and three agree
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         level <= 1'b0;
      end else if (stage[1] == stage[2]) begin
         level <= stage[2];
      end
   end

endmodule : css_pin_sync

// ---- hw/css_startup_timer.sv ----
`timescale 1ns/10ps
module css_startup_timer
   import css_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // start with targets, watchdog tick
   input  wire logic       start,
   input  wire css_delay_t target,
   input  wire logic       tickRise,
   // progress
   output logic            busy,
   output logic            donePulse
);

   css_delay_t goal;
   logic [15:0] ckCnt;
   logic [15:0] tickCnt;
   logic        finished;

   assign finished = (ckCnt >= goal.ckCount) && (tickCnt >= goal.tickCount);

   // both counters run together; cycles on clock, time on ticks
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         goal    <= '0;
         ckCnt   <= 16'h0000;
         tickCnt <= 16'h0000;
      end else if (start) begin
         goal    <= target;
         ckCnt   <= 16'h0000;
         tickCnt <= 16'h0000;
      end else if (busy) begin
         if (ckCnt < goal.ckCount) ckCnt <= ckCnt + 16'h0001;
         if (tickRise && tickCnt < goal.tickCount) tickCnt <= tickCnt + 16'h0001;
      end
   end

   // busy from start until both counts are reached
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy      <= 1'b0;
         donePulse <= 1'b0;
      end else begin
         donePulse <= 1'b0;
         if (start) begin
            busy <= 1'b1;
         end else if (busy && finished) begin
            busy      <= 1'b0;
            donePulse <= 1'b1;
         end
      end
   end

endmodule : css_startup_timer

// ---- hw/css_clock_select.sv ----
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module css_clock_select
   import css_pkg::*;
#(
   parameter int unsigned LF_STABLE_CK = CK_LF_STABLE,
   parameter int unsigned TICKS_65MS_P = TICKS_65MS,
   parameter int unsigned TICKS_64MS_P = TICKS_64MS
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // axi4-lite write address
   input  wire logic [7:0] awaddr,
   input  wire logic       awvalid,
   output logic            awready,
   // axi4-lite write data
   input  wire logic [31:0] wdata,
   input  wire logic [3:0] wstrb,
   input  wire logic       wvalid,
   output logic            wready,
   // axi4-lite write response
   output logic            bvalid,
   output logic [1:0]      bresp,
   input  wire logic       bready,
   // axi4-lite read
   input  wire logic [7:0] araddr,
   input  wire logic       arvalid,
   output logic            arready,
   output logic [31:0]     rdata,
   output logic [1:0]      rresp,
   output logic            rvalid,
   input  wire logic       rready,
   // calibration, watchdog oscillator, sleep controller
   input  wire logic [7:0] calByte,
   input  wire logic       wdtOsc,
   input  wire logic       wakeReq,
   // clock system outputs
   output logic            sysReset_n,
   output logic            wakeDone,
   output logic [2:0]      srcSel,
   output logic            div8En,
   output logic            cfgInvalid,
   output logic [7:0]      rc_trim_register
);

   css_state_t state;
   css_fuse_t  fuseWord;
   css_fuse_t  activeCfg;
   css_delay_t delayTarget;
   logic       kick;
   logic       pendWake;
   logic       restartReq;
   logic       timerBusy;
   logic       timerDone;
   logic       wdtLevel;
   logic       wdtLevelQ;
   logic       tickRise;
   logic       awHave;
   logic       wHave;
   logic [7:0] awAddrQ;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;
   logic       doWrite;
   logic       next_awHave;
   logic       next_wHave;
   logic       addrHit;
   logic [31:0] readWord;
   logic       readHit;

   // delay targets for a fuse word, reset or wake
   function automatic css_delay_t delay_for(input css_fuse_t f, input logic wake);
      css_delay_t d;
      logic       isLf;
      logic       is128;
      isLf  = (f.clockSourceFuses == SRCF_LF_FAST) || (f.clockSourceFuses == SRCF_LF_STABLE);
      is128 = (f.clockSourceFuses == SRCF_128K);
      d     = '0;
      if (wake) begin
         if (isLf) begin
            d.ckCount = f.clockSourceFuses[0] ? 16'(LF_STABLE_CK) : CK_LF_WAKE;
         end else begin
            d.ckCount = CK_INT_WAKE;
         end
      end else begin
         d.ckCount = isLf ? CK_LF_RESET : CK_INT_RESET;
         case (f.startupDelayFuses)
            SUT_SHORT: begin
               if (!isLf && f.resetPinDisableFuse) d.tickCount = 16'(TICKS_4P1MS);
            end
            SUT_MID: begin
               d.tickCount = is128 ? 16'(TICKS_4MS) : 16'(TICKS_4P1MS);
            end
            default: begin
               d.tickCount = is128 ? 16'(TICKS_64MS_P) : 16'(TICKS_65MS_P);
            end
         endcase
      end
      return d;
   endfunction : delay_for

   // watchdog oscillator pin, cleaned and edge-detected
   css_pin_sync u_wdt_sync (
      .clock (clock),
      .rst_n (rst_n),
      .pinIn (wdtOsc),
      .level (wdtLevel)
   );

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wdtLevelQ <= 1'b0;
      end else begin
         wdtLevelQ <= wdtLevel;
      end
   end

   assign tickRise = wdtLevel & ~wdtLevelQ;

   // delay counter shared by reset and wake
   assign delayTarget = delay_for(kick && !pendWake ? fuseWord : activeCfg, pendWake);

   css_startup_timer u_timer (
      .clock     (clock),
      .rst_n     (rst_n),
      .start     (kick),
      .target    (delayTarget),
      .tickRise  (tickRise),
      .busy      (timerBusy),
      .donePulse (timerDone)
   );

   // sequencing of reset hold and wake hold
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state      <= ST_RESET_WAIT;
         kick       <= 1'b1;
         pendWake   <= 1'b0;
         sysReset_n <= 1'b0;
         wakeDone   <= 1'b0;
      end else begin
         kick     <= 1'b0;
         wakeDone <= 1'b0;
         case (state)
            ST_RESET_WAIT: begin
               if (timerDone) begin
                  state      <= ST_RUN;
                  sysReset_n <= 1'b1;
               end
            end
            ST_RUN: begin
               if (restartReq) begin
                  state      <= ST_RESET_WAIT;
                  kick       <= 1'b1;
                  pendWake   <= 1'b0;
                  sysReset_n <= 1'b0;
               end else if (wakeReq) begin
                  state    <= ST_WAKE_WAIT;
                  kick     <= 1'b1;
                  pendWake <= 1'b1;
               end
            end
            ST_WAKE_WAIT: begin
               if (timerDone) begin
                  state    <= ST_RUN;
                  pendWake <= 1'b0;
                  wakeDone <= 1'b1;
               end
            end
            default: begin
               state      <= ST_RESET_WAIT;
               kick       <= 1'b1;
               pendWake   <= 1'b0;
               sysReset_n <= 1'b0;
            end
         endcase
      end
   end

   // configuration taken at the start of each reset hold
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         activeCfg <= css_fuse_t'(FUSE_SHIPPED);
      end else if (kick && !pendWake) begin
         activeCfg <= fuseWord;
      end
   end

   // source decode and divider from the active configuration
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         srcSel     <= SRC_RC;
         div8En     <= 1'b1;
         cfgInvalid <= 1'b0;
      end else begin
         case (activeCfg.clockSourceFuses)
            SRCF_LF_FAST, SRCF_LF_STABLE: srcSel <= SRC_LF;
            SRCF_128K: srcSel <= SRC_128K;
            default: srcSel <= SRC_RC;
         endcase
         div8En     <= activeCfg.divideByEightFuse;
         cfgInvalid <= (activeCfg.startupDelayFuses == SUT_RESERVED) ||
                       !((activeCfg.clockSourceFuses == SRCF_LF_FAST) ||
                         (activeCfg.clockSourceFuses == SRCF_LF_STABLE) ||
                         (activeCfg.clockSourceFuses == SRCF_RC) ||
                         (activeCfg.clockSourceFuses == SRCF_128K));
      end
   end

   // write channel capture, either order
   assign doWrite     = awHave & wHave & ~bvalid;
   assign next_awHave = (awHave & ~doWrite) | (awvalid & awready);
   assign next_wHave  = (wHave & ~doWrite) | (wvalid & wready);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awHave  <= 1'b0;
         wHave   <= 1'b0;
         awready <= 1'b1;
         wready  <= 1'b1;
         awAddrQ <= 8'h00;
         wDataQ  <= 32'h0000_0000;
         wStrbQ  <= 4'h0;
      end else begin
         awHave  <= next_awHave;
         wHave   <= next_wHave;
         awready <= ~next_awHave;
         wready  <= ~next_wHave;
         if (awvalid && awready) awAddrQ <= awaddr;
         if (wvalid && wready) begin
            wDataQ <= wdata;
            wStrbQ <= wstrb;
         end
      end
   end

   assign addrHit = (awAddrQ == OFS_FUSE) || (awAddrQ == OFS_TRIM) ||
                    (awAddrQ == OFS_STATUS) || (awAddrQ == OFS_CONTROL);

   // write response
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (doWrite) begin
         bvalid <= 1'b1;
         bresp  <= addrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // fuse word, programmed by software, used at next reset hold
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fuseWord <= css_fuse_t'(FUSE_SHIPPED);
      end else if (doWrite && awAddrQ == OFS_FUSE && wStrbQ[0]) begin
         fuseWord <= css_fuse_t'(wDataQ[7:0]);
      end
   end

   // trim: factory byte during reset, software afterwards
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rc_trim_register <= calByte;
      end else if (doWrite && awAddrQ == OFS_TRIM && wStrbQ[0]) begin
         rc_trim_register <= wDataQ[7:0];
      end
   end

   // restart request, one cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         restartReq <= 1'b0;
      end else begin
         restartReq <= doWrite && awAddrQ == OFS_CONTROL && wStrbQ[0] && wDataQ[CTRL_RESTART_BIT];
      end
   end

   // read decode
   always_comb begin
      readWord = 32'h0000_0000;
      readHit  = 1'b1;
      case (araddr)
         OFS_FUSE:    readWord[7:0] = fuseWord;
         OFS_TRIM:    readWord[7:0] = rc_trim_register;
         OFS_STATUS:  readWord[8:0] = {pendWake, sysReset_n, timerBusy, cfgInvalid, div8En, state != ST_RUN, srcSel};
         OFS_CONTROL: readWord     = 32'h0000_0000;
         default:     readHit      = 1'b0;
      endcase
   end

   // read channel, one answer outstanding
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= readWord;
         rresp   <= readHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
      end
   end

endmodule : css_clock_select

// ---- test/css_clock_select_properties.sv ----
`timescale 1ns/10ps
module css_clock_select_properties
   import css_pkg::*;
(
   // clock and reset
   input wire logic        clock,
   input wire logic        rst_n,
   // bus handshakes
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic [1:0]  bresp,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic [31:0] rdata,
   input wire logic        rready,
   // clock system
   input wire logic [7:0]  calByte,
   input wire logic        sysReset_n,
   input wire logic        wakeDone,
   input wire logic [2:0]  srcSel,
   input wire logic        div8En,
   input wire logic [7:0]  rc_trim_register
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // outputs just after reset release
   a_reset_values: assert property ($rose(rst_n) |-> !sysReset_n && srcSel == SRC_RC && div8En
      && rc_trim_register == $past(calByte)) else $error("reset values wrong");
   // exactly one source selected
   a_src_onehot: assert property ($onehot(srcSel)) else $error("source select not one-hot");
   // internal reset held at least the shortest count
   a_reset_min: assert property ($rose(sysReset_n) |-> $past(sysReset_n, 4) == 1'b0)
      else $error("reset hold too short");
   // wake completion is a single pulse, only while running
   a_wake_pulse: assert property (wakeDone |-> sysReset_n ##1 !wakeDone) else $error("wake pulse wrong");
   // trim changes only through a register write
   a_trim_write: assert property ($changed(rc_trim_register) |-> ##[0:1] bvalid)
      else $error("trim changed without write");
   // bus answers hold and come on time
   a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
   a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rvalid dropped");
   a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
   a_write_answer: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
      else $error("write answer late");
endmodule : css_clock_select_properties

bind css_clock_select css_clock_select_properties u_props (
   .clock(clock), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bvalid(bvalid), .bresp(bresp), .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
   .rdata(rdata), .rready(rready), .calByte(calByte), .sysReset_n(sysReset_n), .wakeDone(wakeDone),
   .srcSel(srcSel), .div8En(div8En), .rc_trim_register(rc_trim_register));

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench
   import css_pkg::*;
;
   // stimulus and observed signals
   logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready, wakeReq, wdtRun;
   logic        awready, wready, bvalid, arready, rvalid, sysReset_n, wakeDone, div8En, cfgInvalid;
   logic [7:0]  awaddr, araddr, calByte, trim;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [2:0]  wdtDiv, srcSel;
   logic [1:0]  bresp, rresp, rs;
   wire logic   wdtOsc;
   int          error_cnt, checked, n;

   // fuse settings and expected hold figures
   localparam logic [7:0] cfgTab [10] = '{8'h06, 8'h17, 8'h27, 8'h42, 8'h12, 8'hC2, 8'h03, 8'h13, 8'h23, 8'h83};
   localparam logic [2:0] srcTab [10] = '{SRC_LF, SRC_LF, SRC_LF, SRC_RC, SRC_RC, SRC_RC,
                                          SRC_128K, SRC_128K, SRC_128K, SRC_128K};
   localparam int         holdTab [10] = '{4, 4192, 152, 14, 4192, 4192, 14, 4088, 152, 4192};
   localparam int         wakeTab [10] = '{1024, 64, 64, 6, 6, 6, 6, 6, 6, 6};

   // clock and watchdog oscillator, one period per 8 clocks
   always #10 clock = ~clock;
   assign wdtOsc = wdtDiv[2];
   always @(posedge clock) begin
      if (!rst_n) begin
         wdtDiv <= 3'h0;
      end else if (wdtRun) begin
         wdtDiv <= wdtDiv + 3'h1;
      end
   end

   css_clock_select #(.LF_STABLE_CK(64), .TICKS_65MS_P(20), .TICKS_64MS_P(20)) DUT (
      .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .calByte(calByte), .wdtOsc(wdtOsc), .wakeReq(wakeReq),
      .sysReset_n(sysReset_n), .wakeDone(wakeDone), .srcSel(srcSel), .div8En(div8En),
      .cfgInvalid(cfgInvalid), .rc_trim_register(trim));

   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         $display("[FAIL] %0t %s", $time, msg);
         error_cnt++;
      end
   endtask : chk

   // bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input bit late = 1'b0);
      logic ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clock);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= !late;
      while (!(ad && wd)) begin
         @(posedge clock);
         if (awvalid && awready) begin
            ad = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            wd = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clock); while (bvalid !== 1'b1);
      // late ready: response must stand until taken
      if (late) begin
         bready <= 1'b1;
         do @(posedge clock); while (bvalid !== 1'b1);
      end
      bready <= 1'b0;
      chk(bresp, RESP_OKAY, "write response");
   endtask : wr

   // bus read, data and response left in rd and rs
   task automatic rd_reg(input logic [7:0] a, input bit late = 1'b0);
      @(posedge clock);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= !late;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clock); while (rvalid !== 1'b1);
      // late ready: read data must stand until taken
      if (late) begin
         rready <= 1'b1;
         do @(posedge clock); while (rvalid !== 1'b1);
      end
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
   endtask : rd_reg

   // cycles until internal reset falls and rises again
   task automatic hold_len;
      n = 0;
      do begin @(posedge clock); n++; end while (sysReset_n !== 1'b0 && n < 20);
      do begin @(posedge clock); n++; end while (sysReset_n !== 1'b1 && n < 9000);
   endtask : hold_len

   task automatic complete_run;
      $display("errors %0d, checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run

   // hang guard, about 50k clocks
   initial begin
      #1_000_000;
      error_cnt++;
      complete_run();
   end

   // main sequence
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, wakeReq, wdtRun} = 7'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      calByte = 8'hA5;
      repeat (5) @(posedge clock);
      chk(sysReset_n, 1'b0, "reset held");
      chk(srcSel, SRC_RC, "shipped source");
      chk(div8En, 1'b1, "shipped divider");
      chk(trim, 8'hA5, "trim load");
      rst_n <= 1'b1;
      // watchdog stopped: the hold may not end on clock cycles alone
      repeat (300) @(posedge clock);
      chk(sysReset_n, 1'b0, "hold without watchdog");
      wdtRun <= 1'b1;
      hold_len();
      chk(n >= 152 && n <= 200, 1'b1, "shipped hold length");
      rd_reg(OFS_FUSE);
      chk(rd, {24'h0, FUSE_SHIPPED}, "fuse word");
      // trim rewrite, then a write with its byte lane off
      wr(OFS_TRIM, 32'h0000_005A, 4'hF);
      wr(OFS_TRIM, 32'h0000_00C3, 4'h0);
      rd_reg(OFS_TRIM);
      chk(rd, 32'h0000_005A, "trim readback");
      chk(trim, 8'h5A, "trim port");
      rd_reg(8'h40);
      chk(rs, RESP_SLVERR, "unmapped response");
      chk(rd, 32'h0, "unmapped data");
      // each source and startup code except RC with code 10: reset hold, then a wake
      for (int i = 0; i < 10; i++) begin
         wr(OFS_FUSE, {24'h0, cfgTab[i]}, 4'h1);
         wr(OFS_CONTROL, 32'h0000_0001, 4'h1);
         hold_len();
         chk(n >= holdTab[i] && n <= holdTab[i] + 40, 1'b1, "reset hold");
         chk(srcSel, srcTab[i], "source");
         chk(div8En, cfgTab[i][6], "divider");
         chk(cfgInvalid, 1'b0, "valid config");
         @(posedge clock);
         wakeReq <= 1'b1;
         @(posedge clock);
         wakeReq <= 1'b0;
         n = 0;
         do begin @(posedge clock); n++; end while (wakeDone !== 1'b1 && n < 2000);
         chk(n >= wakeTab[i] && n <= wakeTab[i] + 12, 1'b1, "wake hold");
      end
      // reserved startup code and unlisted source code, late bus readies
      wr(OFS_FUSE, 32'h0000_0035, 4'h1, 1'b1);
      wr(OFS_CONTROL, 32'h0000_0001, 4'h1);
      hold_len();
      chk(cfgInvalid, 1'b1, "invalid config");
      rd_reg(OFS_STATUS, 1'b1);
      chk(rd, 32'h0000_00A2, "status word");
      complete_run();
   end
endmodule : testbench
